//--- core/bcc_core.sv
`timescale 1ns/1ns

module bcc_core
    import bcc_pkg::*;
#(
    parameter int unsigned DEFER_CYCLES = DEFER_CYC
) (
    input  wire logic       CLK_SYS,
    input  wire logic       RST_N,
    input  wire logic       CE,
    input  wire logic       OSC_CLK,
    input  wire logic       PTR_LOAD,
    input  wire logic [2:0] PTR_IN,
    input  wire logic       WR_STB,
    input  wire logic [7:0] WR_DATA,
    input  wire logic       RD_STB,
    input  wire logic       ACK_STB,
    input  wire logic       READ_ACTIVE,
    input  wire logic       TEST_PIN_I,
    output logic      [7:0] RD_DATA,
    output logic      [2:0] ADDR_PTR,
    output logic            TEST_PIN_O,
    output logic            TEST_PIN_OE
);

    ////////////////////////////////////////////////////////////////////////
    // Helper functions

    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        logic [7:0] r;
        r = 8'h00;
        if (v[3:0] == 4'h9) begin
            r = {4'(v[7:4] + 4'h1), 4'h0};
        end else begin
            r = {v[7:4], 4'(v[3:0] + 4'h1)};
        end
        return r;
    endfunction : bcd_inc

    function automatic logic is_leap(input logic [7:0] y);
        logic l;
        l = 1'b0;
        if (y[4]) begin
            l = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
        end else begin
            l = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
        end
        return l;
    endfunction : is_leap

    function automatic logic [5:0] last_day(input logic [4:0] m,
                                            input logic [7:0] y);
        logic [5:0] d;
        d = 6'h31;
        case (m)
            5'h02: begin
                d = is_leap(y) ? 6'h29 : 6'h28;
            end
            5'h04, 5'h06, 5'h09, 5'h11: begin
                d = 6'h30;
            end
            default: begin
                d = 6'h31;
            end
        endcase
        return d;
    endfunction : last_day

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    logic            osc_s1_q;
    logic            osc_s2_q;
    logic            osc_s3_q;
    logic            osc_tick;
    logic            halt;
    logic     [15:0] div_q;
    logic     [15:0] div_tc;
    logic            sec_tick;
    logic            adj_sec;
    logic      [5:0] cal_min_q;
    logic      [4:0] tone_div_q;
    logic            tone_q;
    logic      [7:0] ctrl_q;
    bcc_time_s       time_q;
    bcc_time_s       time_inc;
    bcc_time_s       time_d;
    logic            min_wrap;
    logic      [7:0] time_arr [NUM_TIME_REGS];
    logic      [7:0] vis_q    [NUM_TIME_REGS];
    logic     [31:0] defer_cnt_q;
    logic            reading;
    logic            hold_vis;
    logic      [2:0] ptr_q;
    logic      [7:0] rd_data_q;
    logic            pin_oe_q;
    logic            pin_o_q;
    logic            wr_time;

    assign halt    = time_q.sec[HALT_BIT];
    assign wr_time = WR_STB && (ptr_q != ADDR_CTRL);

    ////////////////////////////////////////////////////////////////////////
    // Oscillator input: two flops before any logic, third for the edge

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            osc_s1_q <= 1'b0;
            osc_s2_q <= 1'b0;
            osc_s3_q <= 1'b0;
        end else if (CE) begin
            osc_s1_q <= OSC_CLK;
            osc_s2_q <= osc_s1_q;
            osc_s3_q <= osc_s2_q;
        end
    end

    // Halt gates the oscillator; clearing it resumes at the next edge
    assign osc_tick = osc_s2_q && !osc_s3_q && !halt;

    ////////////////////////////////////////////////////////////////////////
    // Second divider with periodic counter correction

    // First second of an eligible minute is trimmed
    assign adj_sec = (ctrl_q[4:0] != 5'h00)
                  && (time_q.sec[6:0] == 7'h00)
                  && (cal_min_q < {ctrl_q[4:0], 1'b0});

    always_comb begin
        div_tc = TC_NOM;
        if (adj_sec) begin
            // Positive trim ends the second early, negative one late
            div_tc = ctrl_q[SIGN_BIT] ? TC_POS : TC_NEG;
        end
    end

    assign sec_tick = osc_tick && (div_q >= div_tc);

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            div_q <= 16'h0000;
        end else if (CE) begin
            if (WR_STB && (ptr_q == ADDR_SEC)) begin
                // Writing seconds starts a fresh second
                div_q <= 16'h0000;
            end else if (sec_tick) begin
                div_q <= 16'h0000;
            end else if (osc_tick) begin
                div_q <= 16'(div_q + 16'h0001);
            end
        end
    end

    assign min_wrap = sec_tick && (time_q.sec[6:0] == MAX_SEC);

    // Position within the 64-minute calibration cycle
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            cal_min_q <= 6'h00;
        end else if (CE && min_wrap) begin
            cal_min_q <= 6'(cal_min_q + 6'h01);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Test tone, taken straight off the oscillator ahead of the trim

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            tone_div_q <= 5'h00;
            tone_q     <= 1'b0;
        end else if (CE && osc_tick) begin
            if (tone_div_q == TONE_TC) begin
                tone_div_q <= 5'h00;
                tone_q     <= ~tone_q;
            end else begin
                tone_div_q <= 5'(tone_div_q + 5'h01);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Time counters

    always_comb begin
        time_inc = time_q;
        if (time_q.sec[6:0] != MAX_SEC) begin
            time_inc.sec[6:0] = 7'(bcd_inc({1'b0, time_q.sec[6:0]}));
        end else begin
            time_inc.sec[6:0] = 7'h00;
            if (time_q.min[6:0] != MAX_MIN) begin
                time_inc.min[6:0] = 7'(bcd_inc({1'b0, time_q.min[6:0]}));
            end else begin
                time_inc.min[6:0] = 7'h00;
                if (time_q.hour[5:0] != MAX_HOUR) begin
                    time_inc.hour[5:0] =
                        6'(bcd_inc({2'b00, time_q.hour[5:0]}));
                end else begin
                    time_inc.hour[5:0] = 6'h00;
                    time_inc.dow[2:0] = (time_q.dow[2:0] >= MAX_DOW) ?
                        3'h1 : 3'(time_q.dow[2:0] + 3'h1);
                    if (time_q.dom[5:0] <
                        last_day(time_q.mon[4:0], time_q.year)) begin
                        time_inc.dom[5:0] =
                            6'(bcd_inc({2'b00, time_q.dom[5:0]}));
                    end else begin
                        time_inc.dom[5:0] = 6'h01;
                        if (time_q.mon[4:0] < MAX_MON) begin
                            time_inc.mon[4:0] =
                                5'(bcd_inc({3'b000, time_q.mon[4:0]}));
                        end else begin
                            time_inc.mon[4:0] = 5'h01;
                            if (time_q.year != MAX_YEAR) begin
                                time_inc.year = bcd_inc(time_q.year);
                            end else begin
                                time_inc.year = 8'h00;
                                if (time_q.hour[CEN_EN_BIT]) begin
                                    time_inc.hour[CEN_FLAG_BIT] =
                                        ~time_q.hour[CEN_FLAG_BIT];
                                end
                            end
                        end
                    end
                end
            end
        end
    end

    // A write lands on top of whatever tick happens in the same cycle
    always_comb begin
        time_d = sec_tick ? time_inc : time_q;
        if (wr_time) begin
            case (ptr_q)
                ADDR_SEC:  time_d.sec  = WR_DATA & MSK_SEC;
                ADDR_MIN:  time_d.min  = WR_DATA & MSK_MIN;
                ADDR_HOUR: time_d.hour = WR_DATA & MSK_HOUR;
                ADDR_DOW:  time_d.dow  = WR_DATA & MSK_DOW;
                ADDR_DOM:  time_d.dom  = WR_DATA & MSK_DOM;
                ADDR_MON:  time_d.mon  = WR_DATA & MSK_MON;
                ADDR_YEAR: time_d.year = WR_DATA & MSK_YEAR;
                default:   time_d      = time_d;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            time_q <= RST_TIME;
        end else if (CE) begin
            time_q <= time_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control register

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            ctrl_q <= RST_CTRL;
        end else if (CE && WR_STB && (ptr_q == ADDR_CTRL)) begin
            ctrl_q <= WR_DATA;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Readable copies, held for up to DEFER_CYCLES cycles while a clock address is being read

    assign reading  = READ_ACTIVE && (ptr_q != ADDR_CTRL);
    assign hold_vis = reading && (defer_cnt_q < DEFER_CYCLES);

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            defer_cnt_q <= 32'h00000000;
        end else if (CE) begin
            if (!reading) begin
                defer_cnt_q <= 32'h00000000;
            end else if (hold_vis) begin
                defer_cnt_q <= 32'(defer_cnt_q + 32'h00000001);
            end
        end
    end

    always_comb begin
        time_arr[ADDR_SEC]  = time_q.sec;
        time_arr[ADDR_MIN]  = time_q.min;
        time_arr[ADDR_HOUR] = time_q.hour;
        time_arr[ADDR_DOW]  = time_q.dow;
        time_arr[ADDR_DOM]  = time_q.dom;
        time_arr[ADDR_MON]  = time_q.mon;
        time_arr[ADDR_YEAR] = time_q.year;
    end

    // Counters keep running during the hold; copies catch up after it
    for (genvar i = 0; i < NUM_TIME_REGS; i++) begin : g_vis
        always_ff @(posedge CLK_SYS or negedge RST_N) begin
            if (!RST_N) begin
                vis_q[i] <= RST_TIME[8*i +: 8];
            end else if (CE && !hold_vis) begin
                vis_q[i] <= time_arr[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Address pointer and read data

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            ptr_q <= ADDR_SEC;
        end else if (CE) begin
            if (PTR_LOAD) begin
                ptr_q <= PTR_IN;
            end else if (ACK_STB) begin
                ptr_q <= 3'(ptr_q + 3'h1);
            end
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            rd_data_q <= 8'h00;
        end else if (CE && RD_STB) begin
            if (ptr_q == ADDR_CTRL) begin
                rd_data_q <= ctrl_q;
            end else begin
                rd_data_q <= vis_q[ptr_q];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Open-drain test signal pin: enable means pulling low

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            pin_oe_q <= 1'b0;
            pin_o_q  <= 1'b0;
        end else if (CE) begin
            pin_o_q <= 1'b0;
            if (ctrl_q[FT_BIT]) begin
                pin_oe_q <= ~tone_q;
            end else begin
                pin_oe_q <= ~ctrl_q[OUT_BIT];
            end
        end
    end

    assign RD_DATA     = rd_data_q;
    assign ADDR_PTR    = ptr_q;
    assign TEST_PIN_O  = pin_o_q;
    assign TEST_PIN_OE = pin_oe_q;

endmodule : bcc_core

//--- core/bcc_pkg.sv
package bcc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Clocking and timing
    localparam int unsigned SYS_HZ       = 100_000_000;
    localparam int unsigned DEFER_MS     = 250;
    localparam int unsigned DEFER_CYC    = (SYS_HZ / 1000) * DEFER_MS;
    localparam int unsigned OSC_HZ       = 32768;
    localparam int unsigned TRIM_STAGE   = 256;
    localparam int unsigned NEG_TRIM_CNT = 128;
    localparam int unsigned POS_TRIM_CNT = 256;
    localparam int unsigned TONE_HZ      = 512;

    // Oscillator ticks per second, terminal counts of the second divider
    localparam logic [15:0] TC_NOM = 16'(OSC_HZ - 1);
    localparam logic [15:0] TC_POS = 16'(OSC_HZ - 1 - POS_TRIM_CNT);
    localparam logic [15:0] TC_NEG = 16'(OSC_HZ - 1 + NEG_TRIM_CNT);
    // Test tone toggles every half period of 512 Hz
    localparam logic [4:0]  TONE_TC = 5'(OSC_HZ / TONE_HZ / 2 - 1);

    ////////////////////////////////////////////////////////////////////////
    // Register addresses
    localparam logic [2:0] ADDR_SEC  = 3'h0;
    localparam logic [2:0] ADDR_MIN  = 3'h1;
    localparam logic [2:0] ADDR_HOUR = 3'h2;
    localparam logic [2:0] ADDR_DOW  = 3'h3;
    localparam logic [2:0] ADDR_DOM  = 3'h4;
    localparam logic [2:0] ADDR_MON  = 3'h5;
    localparam logic [2:0] ADDR_YEAR = 3'h6;
    localparam logic [2:0] ADDR_CTRL = 3'h7;
    localparam int unsigned NUM_TIME_REGS = 7;

    ////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int unsigned HALT_BIT     = 7;
    localparam int unsigned CEN_EN_BIT   = 7;
    localparam int unsigned CEN_FLAG_BIT = 6;
    localparam int unsigned OUT_BIT      = 7;
    localparam int unsigned FT_BIT       = 6;
    localparam int unsigned SIGN_BIT     = 5;

    // Stored bits of each register; don't-care bits read as zero
    localparam logic [7:0] MSK_SEC  = 8'hff;
    localparam logic [7:0] MSK_MIN  = 8'h7f;
    localparam logic [7:0] MSK_HOUR = 8'hff;
    localparam logic [7:0] MSK_DOW  = 8'h07;
    localparam logic [7:0] MSK_DOM  = 8'h3f;
    localparam logic [7:0] MSK_MON  = 8'h1f;
    localparam logic [7:0] MSK_YEAR = 8'hff;

    // BCD range limits
    localparam logic [6:0] MAX_SEC  = 7'h59;
    localparam logic [6:0] MAX_MIN  = 7'h59;
    localparam logic [5:0] MAX_HOUR = 6'h23;
    localparam logic [2:0] MAX_DOW  = 3'h7;
    localparam logic [4:0] MAX_MON  = 5'h12;
    localparam logic [7:0] MAX_YEAR = 8'h99;

    ////////////////////////////////////////////////////////////////////////
    // Values after reset
    localparam logic [7:0] RST_SEC  = 8'h00;
    localparam logic [7:0] RST_MIN  = 8'h00;
    localparam logic [7:0] RST_HOUR = 8'h00;
    localparam logic [7:0] RST_DOW  = 8'h01;
    localparam logic [7:0] RST_DOM  = 8'h01;
    localparam logic [7:0] RST_MON  = 8'h01;
    localparam logic [7:0] RST_YEAR = 8'h00;
    localparam logic [7:0] RST_CTRL = 8'h80;

    typedef struct packed {
        logic [7:0] year;
        logic [7:0] mon;
        logic [7:0] dom;
        logic [7:0] dow;
        logic [7:0] hour;
        logic [7:0] min;
        logic [7:0] sec;
    } bcc_time_s;

    localparam bcc_time_s RST_TIME = '{year: RST_YEAR, mon: RST_MON,
        dom: RST_DOM, dow: RST_DOW, hour: RST_HOUR, min: RST_MIN,
        sec: RST_SEC};

endpackage : bcc_pkg

//--- testbench/bcc_core_checker.sv
`timescale 1ns/1ns

module bcc_core_checker
    import bcc_pkg::*;
#(
    parameter int unsigned DEFER_CYCLES = DEFER_CYC
) (
    input  wire logic       CLK_SYS,
    input  wire logic       RST_N,
    input  wire logic       CE,
    input  wire logic       OSC_CLK,
    input  wire logic       PTR_LOAD,
    input  wire logic [2:0] PTR_IN,
    input  wire logic       WR_STB,
    input  wire logic [7:0] WR_DATA,
    input  wire logic       RD_STB,
    input  wire logic       ACK_STB,
    input  wire logic       READ_ACTIVE,
    input  wire logic       TEST_PIN_I,
    input  wire logic [7:0] RD_DATA,
    input  wire logic [2:0] ADDR_PTR,
    input  wire logic       TEST_PIN_O,
    input  wire logic       TEST_PIN_OE
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);

    wire logic ctrl_wr = CE && WR_STB && ADDR_PTR == ADDR_CTRL;
    wire logic rd      = CE && RD_STB;

    ////////////////////////////////////////////////////////////////////////
    // Static level write followed by a quiet cycle
    sequence s_static_wr;
        ctrl_wr && !WR_DATA[FT_BIT] ##1 !ctrl_wr;
    endsequence

    property p_pin_static;
        s_static_wr |=> TEST_PIN_OE == !$past(WR_DATA[OUT_BIT], 2);
    endproperty
    property p_pin_drive;
        TEST_PIN_O == 1'b0;
    endproperty
    property p_oe_reset;
        $rose(RST_N) |-> !TEST_PIN_OE;
    endproperty
    property p_ptr_load;
        CE && PTR_LOAD |=> ADDR_PTR == $past(PTR_IN);
    endproperty
    property p_ptr_ack;
        CE && ACK_STB && !PTR_LOAD |=> ADDR_PTR == 3'($past(ADDR_PTR) + 3'h1);
    endproperty
    property p_ptr_hold;
        !(CE && (ACK_STB || PTR_LOAD)) |=> $stable(ADDR_PTR);
    endproperty
    property p_rd_hold;
        !rd |=> $stable(RD_DATA);
    endproperty
    property p_rd_units;
        rd && ADDR_PTR != ADDR_CTRL |=> RD_DATA[3:0] <= 4'h9;
    endproperty
    property p_rd_tens;
        rd && ADDR_PTR <= ADDR_MIN |=> RD_DATA[6:4] <= 3'h5;
    endproperty
    property p_rd_dow;
        rd && ADDR_PTR == ADDR_DOW |=> RD_DATA[7:3] == 5'h00
            && RD_DATA[2:0] != 3'h0;
    endproperty
    property p_rd_mon;
        rd && ADDR_PTR == ADDR_MON |=> RD_DATA[7:5] == 3'h0
            && RD_DATA[4:0] <= 5'h12 && RD_DATA[4:0] != 5'h00;
    endproperty

    a_pin_static: assert property (p_pin_static)
        else $error("pin level does not follow written level bit");
    a_pin_drive: assert property (p_pin_drive)
        else $error("test pin driven high");
    a_oe_reset: assert property (p_oe_reset)
        else $error("test pin pulled low after reset");
    a_ptr_load: assert property (p_ptr_load)
        else $error("pointer not loaded");
    a_ptr_ack: assert property (p_ptr_ack)
        else $error("pointer did not advance by one on ack");
    a_ptr_hold: assert property (p_ptr_hold)
        else $error("pointer moved without load or ack");
    a_rd_hold: assert property (p_rd_hold)
        else $error("read data changed without read strobe");
    a_rd_units: assert property (p_rd_units)
        else $error("units digit not decimal");
    a_rd_tens: assert property (p_rd_tens)
        else $error("tens digit of seconds or minutes above 5");
    a_rd_dow: assert property (p_rd_dow)
        else $error("day of week out of range");
    a_rd_mon: assert property (p_rd_mon)
        else $error("month out of range");
endmodule : bcc_core_checker

bind bcc_core bcc_core_checker #(
    .DEFER_CYCLES(DEFER_CYCLES)
) bcc_core_checker_inst (
    .CLK_SYS(CLK_SYS), .RST_N(RST_N), .CE(CE), .OSC_CLK(OSC_CLK),
    .PTR_LOAD(PTR_LOAD), .PTR_IN(PTR_IN), .WR_STB(WR_STB),
    .WR_DATA(WR_DATA), .RD_STB(RD_STB), .ACK_STB(ACK_STB),
    .READ_ACTIVE(READ_ACTIVE), .TEST_PIN_I(TEST_PIN_I),
    .RD_DATA(RD_DATA), .ADDR_PTR(ADDR_PTR), .TEST_PIN_O(TEST_PIN_O),
    .TEST_PIN_OE(TEST_PIN_OE)
);

//--- testbench/bcc_core_test.sv
`timescale 1ns/1ns

module bcc_core_test;
    import bcc_pkg::*;
    // Short hold so the deferral window fits the run
    localparam int unsigned DEFER_T = 50;

    logic        clk_sys, rst_n, osc_clk, read_active, test_pin, ce;
    logic        ptr_load, wr_stb, rd_stb, ack_stb, pin_o, pin_oe;
    logic [2:0]  ptr_in, addr_ptr;
    logic [7:0]  wr_data, rd_data;
    logic [31:0] lfsr;
    logic [7:0]  exp_q[$];
    logic [7:0]  img[8] = '{RST_SEC, RST_MIN, RST_HOUR, RST_DOW, RST_DOM,
                            RST_MON, RST_YEAR, RST_CTRL};
    logic [7:0]  msk[7] = '{MSK_SEC, MSK_MIN, MSK_HOUR, MSK_DOW, MSK_DOM,
                            MSK_MON, MSK_YEAR};
    int          lim[7] = '{60, 60, 24, 7, 28, 12, 100};
    int          base[7] = '{0, 0, 0, 1, 1, 1, 0};
    int          n_fail, total_checks, cyc, gap;

    // Open-drain pin with its pull-up
    assign test_pin = pin_oe ? pin_o : 1'b1;

    bcc_core #(.DEFER_CYCLES(DEFER_T)) bcc_core_inst (
        .CLK_SYS(clk_sys), .RST_N(rst_n), .CE(ce), .OSC_CLK(osc_clk),
        .PTR_LOAD(ptr_load), .PTR_IN(ptr_in), .WR_STB(wr_stb),
        .WR_DATA(wr_data), .RD_STB(rd_stb), .ACK_STB(ack_stb),
        .READ_ACTIVE(read_active), .TEST_PIN_I(test_pin),
        .RD_DATA(rd_data), .ADDR_PTR(addr_ptr), .TEST_PIN_O(pin_o),
        .TEST_PIN_OE(pin_oe)
    );

    bcc_master bcc_master_inst (
        .clk(clk_sys), .ptr_load(ptr_load), .ptr_in(ptr_in),
        .wr_stb(wr_stb), .wr_data(wr_data), .rd_stb(rd_stb),
        .ack_stb(ack_stb)
    );

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // Oscillator at an unrelated phase to the system clock
    initial begin
        osc_clk = 1'b0;
        #37;
        forever #80 osc_clk = ~osc_clk;
    end

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nxt

    function automatic logic [7:0] bcd(input int n);
        return 8'((n / 10) * 16 + n % 10);
    endfunction : bcd

    task automatic check(input string nm, input logic [7:0] seen,
                         input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic summarize();
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : summarize

    task automatic rd_exp(input logic [7:0] e);
        exp_q.push_back(e);
        bcc_master_inst.get();
    endtask : rd_exp

    // Cycles between two successive pin edges, capped at 2000
    task automatic tone_gap(output int g);
        logic p;
        g = 0;
        @(negedge clk_sys);
        p = pin_oe;
        while (pin_oe === p && g < 2000) begin
            @(negedge clk_sys);
            g++;
        end
        p = pin_oe;
        g = 0;
        while (pin_oe === p && g < 2000) begin
            @(negedge clk_sys);
            g++;
        end
    endtask : tone_gap

    ////////////////////////////////////////////////////////////////////////
    // Read data lands one cycle after the strobe
    always @(posedge clk_sys) begin
        if (rst_n === 1'b1 && rd_stb === 1'b1) begin
            @(negedge clk_sys);
            if (exp_q.size() == 0) check("unexpected_read", 8'h00, 8'hff);
            else check("rd_data", rd_data, exp_q.pop_front());
        end
    end

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 30000) begin
            n_fail++;
            summarize();
        end
    end

    initial begin
        rst_n = 1'b0;
        read_active = 1'b0;
        ce = 1'b1;
        lfsr = 32'h5e4a0156;
        n_fail = 0;
        total_checks = 0;
        cyc = 0;
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        rst_n = 1'b1;
        check("oe_reset", {7'h00, pin_oe}, 8'h00);
        // Whole map in one walk, wrapping past the control register
        bcc_master_inst.set_ptr(ADDR_SEC);
        for (int r = 0; r < 8; r++) rd_exp(img[r]);
        rd_exp(img[0]);
        check("ptr_wrap", {5'h00, addr_ptr}, 8'h01);
        // Random BCD image with junk in the unused bits; clock halted
        bcc_master_inst.set_ptr(ADDR_SEC);
        for (int r = 0; r < 7; r++) begin
            lfsr = nxt(lfsr);
            img[r] = bcd(int'(lfsr[15:0] % lim[r]) + base[r]);
            if (r == 0) img[r][HALT_BIT] = 1'b1;
            if (r == 2) img[r][7:6] = lfsr[31:30];
            bcc_master_inst.put(img[r] | (lfsr[23:16] & ~msk[r]));
        end
        bcc_master_inst.set_ptr(ADDR_SEC);
        for (int r = 0; r < 7; r++) rd_exp(img[r]);
        // Write during a read keeps the old copy until the hold ends
        bcc_master_inst.set_ptr(ADDR_MIN);
        @(negedge clk_sys);
        read_active = 1'b1;
        bcc_master_inst.put(8'h42);
        bcc_master_inst.set_ptr(ADDR_MIN);
        rd_exp(img[1]);
        repeat (DEFER_T + 10) @(negedge clk_sys);
        bcc_master_inst.set_ptr(ADDR_MIN);
        rd_exp(8'h42);
        @(negedge clk_sys);
        read_active = 1'b0;
        // Static pin levels
        for (int v = 0; v < 2; v++) begin
            bcc_master_inst.set_ptr(ADDR_CTRL);
            bcc_master_inst.put(8'(v << OUT_BIT));
            repeat (3) @(negedge clk_sys);
            check("pin_level", {7'h00, test_pin}, 8'(v));
        end
        // Restart the oscillator, then test tone under two trims
        bcc_master_inst.set_ptr(ADDR_SEC);
        bcc_master_inst.put(img[0] & 8'h7f);
        for (int k = 0; k < 2; k++) begin
            bcc_master_inst.set_ptr(ADDR_CTRL);
            bcc_master_inst.put(k == 0 ? 8'h7f : 8'h5f);
            tone_gap(gap);
            check("tone_gap", 8'(gap >= 510 && gap <= 514),
                  8'h01);
        end
        bcc_master_inst.set_ptr(ADDR_CTRL);
        rd_exp(8'h5f);
        // Halting the oscillator silences the tone
        bcc_master_inst.set_ptr(ADDR_SEC);
        bcc_master_inst.put(img[0] | 8'h80);
        tone_gap(gap);
        check("tone_halted", 8'(gap >= 2000), 8'h01);
        // Enable low: a pointer load must be ignored entirely
        ce = 1'b0;
        bcc_master_inst.set_ptr(ADDR_YEAR);
        @(negedge clk_sys);
        ce = 1'b1;
        check("ce_freeze", {5'h00, addr_ptr}, 8'h01);
        repeat (3) @(negedge clk_sys);
        check("queue_left", 8'(exp_q.size()), 8'h00);
        summarize();
    end
endmodule : bcc_core_test

//--- testbench/bcc_master.sv
`timescale 1ns/1ns

// Register-port side of the serial bus master; drives at the falling edge
module bcc_master (
    input  wire logic       clk,
    output logic            ptr_load,
    output logic [2:0]      ptr_in,
    output logic            wr_stb,
    output logic [7:0]      wr_data,
    output logic            rd_stb,
    output logic            ack_stb
);
    initial begin
        ptr_load = 1'b0;
        ptr_in   = 3'h0;
        wr_stb   = 1'b0;
        wr_data  = 8'h00;
        rd_stb   = 1'b0;
        ack_stb  = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Word address byte loads the pointer
    task automatic set_ptr(input logic [2:0] a);
        @(negedge clk);
        ptr_load = 1'b1;
        ptr_in   = a;
        @(negedge clk);
        ptr_load = 1'b0;
        ptr_in   = ~a; // Stale value never left on the bus
    endtask : set_ptr

    // Data byte with its acknowledge in the same cycle
    task automatic put(input logic [7:0] d);
        @(negedge clk);
        wr_stb  = 1'b1;
        wr_data = d;
        ack_stb = 1'b1;
        @(negedge clk);
        wr_stb  = 1'b0;
        ack_stb = 1'b0;
        wr_data = ~d;
    endtask : put

    // Read byte acknowledged at once; pointer moves after the capture
    task automatic get();
        @(negedge clk);
        rd_stb  = 1'b1;
        ack_stb = 1'b1;
        @(negedge clk);
        rd_stb  = 1'b0;
        ack_stb = 1'b0;
    endtask : get
endmodule : bcc_master
